// ---- logic/shm_map.svh ----
// offsets, timing figures and sizes for the shared memory slave
`ifndef SHM_MAP_SVH
`define SHM_MAP_SVH
`define SHM_CLK_NS 5
`define SHM_ROM_CS_NS 150
`define SHM_RD_NS 100
`define SHM_WR_NS 150
`define SHM_WE_EDGE_NS 25
`define SHM_ISA_CMD_NS 250
`define SHM_ISA_GAP_NS 100
`define SHM_WINDOW_BYTES 65536
`define SHM_FIFO_DEPTH 8
`define SHM_HI_BYTE 8
`endif

// ---- logic/shm_pkg.sv ----
// types shared by both ends of the shared memory link
package shm_pkg;
  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_ROM = 2'b01,
    P_RD = 2'b11,
    P_WR = 2'b10
  } pbus_state_t;

  typedef enum logic [2:0] {
    OWN_NONE = 3'h0,
    OWN_ROM = 3'h1,
    OWN_FILL = 3'h2,
    OWN_POST = 3'h3,
    OWN_PF = 3'h4,
    OWN_NET = 3'h5
  } owner_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SETUP = 2'b01,
    H_CMD = 2'b11,
    H_GAP = 2'b10
  } host_state_t;

  typedef struct packed {
    logic rom;
    logic we;
    logic wide;
    logic [15:0] addr;
    logic [15:0] data;
  } cmd_t;

  typedef struct packed {
    pbus_state_t st;
    owner_t own;
    logic [5:0] tmr;
    logic byte_ix;
    logic two;
    logic [15:0] paddr;
    logic [7:0] pwdata;
    logic [7:0] lo_byte;
    logic sbhe_seen;
    logic served;
    logic sr_served;
    logic drive;
    logic [15:0] sd;
    logic post_full;
    logic post_wide;
    logic [15:0] post_addr;
    logic [15:0] post_data;
    logic pf_valid;
    logic pf_want;
    logic [14:0] pf_tag;
    logic [14:0] pf_next;
    logic [15:0] pf_data;
    logic net_ack;
    logic [7:0] net_rdata;
  } dev_state_t;

  typedef struct packed {
    host_state_t st;
    logic [5:0] tmr;
    cmd_t cmd;
    logic rsp_valid;
    logic [15:0] rsp_data;
  } host_reg_t;
endpackage

// ---- logic/shm_if.sv ----
// isa memory-cycle signals between the host end and the device end
`timescale 1ns/10ps
interface shm_if;
  logic [15:0] sa;
  logic sbhe;
  logic memr;
  logic memw;
  logic refresh;
  logic rom_window_match;
  logic sram_window_match;
  logic memcs16;
  logic [15:0] hsd;
  logic hsd_oe_n;
  logic [15:0] dsd;
  logic dsd_oe_n;
  logic iochrdy_oe_n;
  logic [15:0] sd;
  logic iochrdy;

  // wire resolution: iochrdy pulled up, data bus from whichever end drives
  assign iochrdy = iochrdy_oe_n;
  assign sd = !dsd_oe_n ? dsd : (!hsd_oe_n ? hsd : 16'h0000);

  modport dev (
    input sa, sbhe, memr, memw, refresh, rom_window_match, sram_window_match, memcs16, sd,
    output dsd, dsd_oe_n, iochrdy_oe_n
  );
  modport host (
    output sa, sbhe, memr, memw, refresh, rom_window_match, sram_window_match, memcs16,
    output hsd, hsd_oe_n,
    input sd, iochrdy
  );
endinterface

// ---- logic/shm_fifo.sv ----
// parameterised command fifo with valid/ready on both sides
`timescale 1ns/10ps
module shm_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 8
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // async reset, high
  input wire logic in_valid_i, // write side valid
  output logic in_ready_o, // write side ready
  input wire logic [WIDTH-1:0] in_data_i, // write data
  output logic out_valid_o, // read side valid
  input wire logic out_ready_i, // read side ready
  output logic [WIDTH-1:0] out_data_o // read data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_state_t;

  fifo_state_t q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready_o = (q.wp ^ q.rp) != {1'b1, {AW{1'b0}}};
  assign out_valid_o = q.wp != q.rp;
  assign out_data_o = mem[q.rp[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    d = q;
    if (push) begin
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[q.wp[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// ---- logic/shm_host.sv ----
// isa permanent master with window decode, driving memory cycles from a fifo
`timescale 1ns/10ps
`include "shm_map.svh"
module shm_host #(
  parameter int DEPTH = `SHM_FIFO_DEPTH,
  parameter bit MEMCS16_EN = 1'b1,
  parameter bit ROM16_DECODE = 1'b1
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // async reset, high
  shm_if.host isa, // isa side
  input wire logic refresh_i, // refresh cycle in progress
  input wire logic cmd_valid_i, // command offered
  output logic cmd_ready_o, // fifo has room
  input wire shm_pkg::cmd_t cmd_i, // command
  output logic rsp_valid_o, // read data pulse
  output logic [15:0] rsp_data_o // read data
);
  import shm_pkg::*;

  localparam int CMD_CYC = (`SHM_ISA_CMD_NS + `SHM_CLK_NS - 1) / `SHM_CLK_NS;
  localparam int GAP_CYC = (`SHM_ISA_GAP_NS + `SHM_CLK_NS - 1) / `SHM_CLK_NS;

  if (CMD_CYC > 63 || GAP_CYC > 63) begin : g_bad
    $error("isa timing counts exceed the timer");
  end

  host_reg_t q, d;
  logic f_valid, f_ready;
  cmd_t f_data;
  logic active, match;

  shm_fifo #(.WIDTH($bits(cmd_t)), .DEPTH(DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(cmd_valid_i),
    .in_ready_o(cmd_ready_o),
    .in_data_i(cmd_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode and bus drive
  assign f_ready = (q.st == H_IDLE) && !refresh_i;
  assign active = q.st == H_SETUP || q.st == H_CMD;
  assign match = active && !refresh_i; // see RULE2
  assign isa.sa = q.cmd.addr;
  assign isa.sbhe = active && q.cmd.wide;
  assign isa.refresh = refresh_i;
  assign isa.rom_window_match = match && q.cmd.rom; // see RULE2
  assign isa.sram_window_match = match && !q.cmd.rom; // see RULE8
  // see RULE3
  // see RULE9
  // see RULE19
  assign isa.memcs16 = match && MEMCS16_EN && (!q.cmd.rom || ROM16_DECODE);
  assign isa.memr = q.st == H_CMD && !q.cmd.we;
  assign isa.memw = q.st == H_CMD && q.cmd.we;
  assign isa.hsd = q.cmd.data;
  assign isa.hsd_oe_n = !(q.st == H_CMD && q.cmd.we);
  assign rsp_valid_o = q.rsp_valid;
  assign rsp_data_o = q.rsp_data;

  ////////////////////////////////////////////////////////////////////////////
  // cycle sequencer
  always_comb begin
    d = q;
    d.rsp_valid = 1'b0;
    unique case (q.st)
      H_IDLE: begin
        if (f_valid && f_ready) begin
          d.cmd = f_data;
          d.st = H_SETUP;
        end
      end
      H_SETUP: begin
        d.tmr = '0;
        d.st = H_CMD;
      end
      H_CMD: begin
        if (q.tmr < 6'(CMD_CYC - 1)) begin
          d.tmr = q.tmr + 6'h01;
        end else if (isa.iochrdy) begin
          d.rsp_valid = !q.cmd.we;
          d.rsp_data = isa.sd;
          d.tmr = '0;
          d.st = H_GAP;
        end
      end
      H_GAP: begin
        if (q.tmr < 6'(GAP_CYC - 1)) begin
          d.tmr = q.tmr + 6'h01;
        end else begin
          d.st = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ---- logic/shm_device.sv ----
// device end: isa memory slave for boot rom and shared sram on a private bus
`timescale 1ns/10ps
`include "shm_map.svh"
// Operation
// RULE1: rom read bytewise, 64 Kbyte private window
// RULE2: decoder makes rom match, refresh gated
// RULE3: decoder asserts memcs16 for wide rom
// RULE4: config bit selects rom cycle width
// RULE5: wide rom read: hold ready, two bytes
// RULE6: rom select low three slow-clock cycles
// RULE7: board ties rom select, output enable
// RULE8: decoder makes sram window match
// RULE9: sram cycles are 16-bit, decoder memcs16
// RULE10: sram access starts on qualified command
// RULE11: sram writes posted to holding register
// RULE12: full holding register stalls next write
// RULE13: sram read waits for private bus
// RULE14: tag miss fills word, then hit
// RULE15: hit drives word, then new prefetch
// RULE16: prefetch incrementing words between cycles
// RULE17: other private activity invalidates prefetch
// RULE18: without byte-high seen, all cycles 8-bit
// RULE19: 8-bit board never asserts memcs16
// RULE20: sram read two slow periods
// RULE21: board holds sram select asserted
// RULE22: sram write three periods, inner strobe
// RULE23: all timing from one clock
// RULE24: one private bus owner at once
module shm_device (
  input wire logic clk_i, // clock
  input wire logic rst_i, // async reset, high
  shm_if.dev isa, // isa side
  input wire logic rom_wide_cycles_i, // rom cycles 16-bit when set and byte-high seen
  output logic [15:0] private_addr_o, // private address bus
  input wire logic [7:0] private_data_bus_i, // private data in
  output logic [7:0] private_data_bus_o, // private data out
  output logic private_data_bus_oe_n_o, // low while driving
  output logic rom_chip_select_n_o, // rom select, low
  output logic sram_output_enable_n_o, // sram output enable, low
  output logic sram_write_strobe_n_o, // sram write strobe, low
  input wire logic net_req_i, // network access request
  input wire logic net_we_i, // network write
  input wire logic [15:0] net_addr_i, // network address
  input wire logic [7:0] net_wdata_i, // network write data
  output logic net_ack_o, // network access done pulse
  output logic [7:0] net_rdata_o, // network read data
  output logic sbhe_seen_o // byte-high seen since reset
);
  import shm_pkg::*;

  // see RULE23
  localparam int ROM_CYC = (`SHM_ROM_CS_NS + `SHM_CLK_NS - 1) / `SHM_CLK_NS;
  localparam int RD_CYC = (`SHM_RD_NS + `SHM_CLK_NS - 1) / `SHM_CLK_NS;
  localparam int WR_CYC = (`SHM_WR_NS + `SHM_CLK_NS - 1) / `SHM_CLK_NS;
  localparam int WE_CYC = (`SHM_WE_EDGE_NS + `SHM_CLK_NS - 1) / `SHM_CLK_NS;

  if (ROM_CYC > 63 || RD_CYC > 63 || WR_CYC > 63 || `SHM_WINDOW_BYTES > 65536) begin : g_bad
    $error("private bus timing exceeds the timer");
  end

  // last timer value of a private bus phase
  function automatic logic [5:0] last_tick(input pbus_state_t s);
    unique case (s)
      P_ROM: last_tick = 6'(ROM_CYC - 1);
      P_RD: last_tick = 6'(RD_CYC - 1);
      P_WR: last_tick = 6'(WR_CYC - 1);
      P_IDLE: last_tick = 6'h00;
    endcase
  endfunction

  dev_state_t q, d;
  logic wide16, rom_cyc, rom16, sr_cyc, sr_rd, sr_wr, hit, hold_low;
  logic [7:0] pick;

  ////////////////////////////////////////////////////////////////////////////
  // isa cycle qualification
  always_comb begin
    wide16 = q.sbhe_seen && isa.memcs16; // see RULE18
    rom_cyc = isa.memr && isa.rom_window_match && !isa.refresh;
    rom16 = rom_cyc && rom_wide_cycles_i && wide16; // see RULE4
    sr_cyc = (isa.memr || isa.memw) && isa.sram_window_match && !isa.refresh; // see RULE10
    sr_rd = sr_cyc && isa.memr;
    sr_wr = sr_cyc && isa.memw;
    hit = q.pf_valid && q.pf_tag == isa.sa[15:1] && !q.post_full; // see RULE14
    pick = isa.sa[0] ? q.pf_data[15:8] : q.pf_data[7:0];
    // see RULE5
    // see RULE12
    // see RULE13
    hold_low = (rom_cyc && !q.served) || (sr_rd && !q.served && !hit)
      || (sr_wr && !q.served && q.post_full);
  end

  assign isa.iochrdy_oe_n = !hold_low;
  assign isa.dsd = q.sd;
  assign isa.dsd_oe_n = !(q.drive && isa.memr); // see RULE15
  assign private_addr_o = q.paddr;
  assign private_data_bus_o = q.pwdata;
  assign private_data_bus_oe_n_o = q.st != P_WR; // see RULE22
  assign rom_chip_select_n_o = q.st != P_ROM; // see RULE6
  assign sram_output_enable_n_o = q.st != P_RD; // see RULE20
  // see RULE22
  assign sram_write_strobe_n_o = !(q.st == P_WR && q.tmr >= 6'(WE_CYC)
    && q.tmr < 6'(WR_CYC - WE_CYC));
  assign net_ack_o = q.net_ack;
  assign net_rdata_o = q.net_rdata;
  assign sbhe_seen_o = q.sbhe_seen;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d = q;
    d.net_ack = 1'b0;
    if (isa.sbhe) begin
      d.sbhe_seen = 1'b1; // see RULE18
    end

    // end of the isa cycle releases the data bus
    if (!rom_cyc && !sr_cyc) begin
      d.served = 1'b0;
      d.drive = 1'b0;
      if (q.sr_served) begin
        d.sr_served = 1'b0;
        d.pf_want = 1'b1; // see RULE15
        d.pf_next = q.pf_tag + 15'h0001; // see RULE16
      end
    end

    // read hit answers at once
    if (sr_rd && !q.served && hit) begin
      d.sd = wide16 ? q.pf_data : {8'h00, pick}; // see RULE15
      d.served = 1'b1;
      d.sr_served = 1'b1;
      d.drive = 1'b1;
    end

    // posted write
    if (sr_wr && !q.served && !q.post_full) begin
      d.served = 1'b1; // see RULE11
      d.post_full = 1'b1;
      d.post_wide = wide16 && isa.sbhe; // see RULE9
      d.post_addr = d.post_wide ? {isa.sa[15:1], 1'b0} : isa.sa;
      // single byte of a 16-bit cycle: odd address rides the high lane
      d.post_data = d.post_wide ? isa.sd
        : {8'h00, (wide16 && isa.sa[0]) ? isa.sd[15:8] : isa.sd[7:0]};
    end

    // private bus engine, one owner at a time
    unique case (q.st)
      P_IDLE: begin
        d.tmr = '0;
        d.byte_ix = 1'b0;
        if (rom_cyc && !q.served) begin
          d.st = P_ROM; // see RULE24
          d.own = OWN_ROM;
          d.two = rom16; // see RULE5
          d.paddr = rom16 ? {isa.sa[15:1], 1'b0} : isa.sa; // see RULE1
          d.pf_valid = 1'b0; // see RULE17
        end else if (q.post_full) begin
          d.st = P_WR; // see RULE11
          d.own = OWN_POST;
          d.two = q.post_wide;
          d.paddr = q.post_addr;
          d.pwdata = q.post_data[7:0];
          d.pf_valid = 1'b0; // see RULE17
        end else if (sr_rd && !q.served && !hit) begin
          d.st = P_RD; // see RULE14
          d.own = OWN_FILL;
          d.two = 1'b1;
          d.paddr = {isa.sa[15:1], 1'b0};
        end else if (net_req_i && !q.net_ack) begin // see RULE24
          d.st = net_we_i ? P_WR : P_RD;
          d.own = OWN_NET;
          d.two = 1'b0;
          d.paddr = net_addr_i;
          d.pwdata = net_wdata_i;
          d.pf_valid = 1'b0; // see RULE17
        end else if (q.pf_want) begin
          d.st = P_RD; // see RULE16
          d.own = OWN_PF;
          d.two = 1'b1;
          d.pf_want = 1'b0;
          d.paddr = {q.pf_next, 1'b0};
        end
      end
      P_ROM, P_RD, P_WR: begin
        if (q.tmr != last_tick(q.st)) begin
          d.tmr = q.tmr + 6'h01;
        end else if (q.two && !q.byte_ix) begin
          d.tmr = '0;
          d.byte_ix = 1'b1;
          d.lo_byte = private_data_bus_i;
          d.paddr = q.paddr + 16'h0001;
          d.pwdata = q.post_data[15:8];
        end else begin
          d.st = P_IDLE;
          d.own = OWN_NONE;
          unique case (q.own)
            OWN_ROM: begin
              d.sd = q.two ? {private_data_bus_i, q.lo_byte} : {8'h00, private_data_bus_i};
              d.served = 1'b1; // see RULE5
              d.drive = 1'b1;
            end
            OWN_FILL, OWN_PF: begin
              d.pf_data = {private_data_bus_i, q.lo_byte};
              d.pf_tag = q.paddr[15:1];
              d.pf_valid = 1'b1;
              // waiting read served here, so ready rises with data on the bus
              if (sr_rd && !q.served && isa.sa[15:1] == q.paddr[15:1]) begin
                d.sd = wide16 ? {private_data_bus_i, q.lo_byte}
                  : {8'h00, isa.sa[0] ? private_data_bus_i : q.lo_byte}; // see RULE14
                d.served = 1'b1;
                d.sr_served = 1'b1;
                d.drive = 1'b1;
              end
            end
            OWN_POST: begin
              d.post_full = 1'b0; // see RULE12
            end
            OWN_NET: begin
              d.net_ack = 1'b1;
              d.net_rdata = private_data_bus_i;
            end
            default: begin
              d.own = OWN_NONE;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ---- bench/shm_chk.sv ----
// assertion checker for the isa link and the private bus strobes
`timescale 1ns/10ps
module shm_chk (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic sbhe, // byte high
  input wire logic memr, // read cmd
  input wire logic memw, // write cmd
  input wire logic rom_window_match, // rom decode
  input wire logic sram_window_match, // sram decode
  input wire logic dsd_oe_n, // device data drive
  input wire logic iochrdy_oe_n, // ready pulled low
  input wire logic rom_chip_select_n_o, // rom select
  input wire logic sram_output_enable_n_o, // sram oe
  input wire logic sram_write_strobe_n_o, // sram strobe
  input wire logic private_data_bus_oe_n_o, // data drive
  input wire logic sbhe_seen_o // byte high seen
);
  logic [7:0] cs_q;
  logic [7:0] oe_q;
  logic [7:0] we_q;
  logic [7:0] rdy_q;
  //////////////////////////////////////////////////
  // low-time counters
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_q <= 8'h00;
      oe_q <= 8'h00;
      we_q <= 8'h00;
      rdy_q <= 8'h00;
    end else begin
      cs_q <= rom_chip_select_n_o ? 8'h00 : cs_q + 8'h01;
      oe_q <= sram_output_enable_n_o ? 8'h00 : oe_q + 8'h01;
      we_q <= sram_write_strobe_n_o ? 8'h00 : we_q + 8'h01;
      rdy_q <= iochrdy_oe_n ? 8'h00 : (rdy_q == 8'hff ? 8'hff : rdy_q + 8'h01);
    end
  end
  //////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_data_lead;
    $past(!private_data_bus_oe_n_o, 5);
  endsequence
  sequence s_data_tail;
    !private_data_bus_oe_n_o [*5];
  endsequence
  AST_ROM_SELECT: assert property ($rose(rom_chip_select_n_o) |-> cs_q == 8'h1e || cs_q == 8'h3c)
    else $error("rom select width wrong");
  AST_ROM_NARROW: assert property (!sbhe_seen_o && $rose(rom_chip_select_n_o) |-> cs_q == 8'h1e)
    else $error("narrow rom read not one byte");
  AST_READ_OE: assert property ($rose(sram_output_enable_n_o) |-> oe_q == 8'h14 || oe_q == 8'h28)
    else $error("sram read width wrong");
  AST_WRITE_STROBE: assert property ($rose(sram_write_strobe_n_o) |-> we_q == 8'h14)
    else $error("sram strobe width wrong");
  AST_STROBE_SETUP: assert property ($fell(sram_write_strobe_n_o) |-> s_data_lead)
    else $error("strobe before data setup");
  AST_STROBE_HOLD: assert property ($rose(sram_write_strobe_n_o) |-> s_data_tail)
    else $error("data released too soon");
  AST_ONE_OWNER: assert property ($onehot0({!rom_chip_select_n_o, !sram_output_enable_n_o,
    !private_data_bus_oe_n_o}))
    else $error("two private bus owners");
  AST_READY_BOUND: assert property (rdy_q <= 8'hc8)
    else $error("ready held low too long");
  AST_READY_IN_CYCLE: assert property (!iochrdy_oe_n |-> (memr || memw) &&
    (rom_window_match || sram_window_match))
    else $error("ready low outside a cycle");
  AST_DATA_ON_RELEASE: assert property ($rose(iochrdy_oe_n) && memr |-> !dsd_oe_n)
    else $error("ready released without data");
  AST_DRIVE_HOLD: assert property (memr && !dsd_oe_n |=> !memr || !dsd_oe_n)
    else $error("data dropped during read");
  AST_SBHE_STICKY: assert property ($rose(sbhe_seen_o) |-> $past(sbhe))
    else $error("byte high seen without cause");
endmodule

// ---- bench/tb_top.sv ----
// bench: host and device ends joined, private rom and sram modelled
`timescale 1ns/10ps
module tb_top;
  import shm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic refresh_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic cmd_ready_o;
  cmd_t cmd_i = '0;
  logic rsp_valid_o;
  logic [15:0] rsp_data_o;
  logic rom_wide_cycles_i = 1'b0;
  logic [15:0] private_addr_o;
  logic [7:0] private_data_bus_i;
  logic [7:0] private_data_bus_o;
  logic private_data_bus_oe_n_o, rom_chip_select_n_o, sram_output_enable_n_o;
  logic sram_write_strobe_n_o, net_ack_o, sbhe_seen_o;
  logic net_req_i = 1'b0;
  logic net_we_i = 1'b0;
  logic [15:0] net_addr_i = 16'h0000;
  logic [7:0] net_wdata_i = 8'h00;
  logic [7:0] net_rdata_o;
  logic [7:0] noise_q = 8'h00;
  logic [7:0] mem [0:65535];
  logic [7:0] ref_mem [0:65535];
  logic [31:0] exp_q [$];
  logic [31:0] e;
  int seed = 32'h90e0;
  int fail_count = 0;
  int checks = 0;
  int stall = 0;
  bit wide_seen = 1'b0;
  bit refused = 1'b0;
  always #2.5 clk_i = ~clk_i;
  shm_if shm_if_i ();
  shm_host shm_host_i (.clk_i(clk_i), .rst_i(rst_i), .isa(shm_if_i.host), .refresh_i(refresh_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o));
  shm_device shm_device_i (.clk_i(clk_i), .rst_i(rst_i), .isa(shm_if_i.dev),
    .rom_wide_cycles_i(rom_wide_cycles_i), .private_addr_o(private_addr_o),
    .private_data_bus_i(private_data_bus_i), .private_data_bus_o(private_data_bus_o),
    .private_data_bus_oe_n_o(private_data_bus_oe_n_o), .rom_chip_select_n_o(rom_chip_select_n_o),
    .sram_output_enable_n_o(sram_output_enable_n_o), .sram_write_strobe_n_o(sram_write_strobe_n_o),
    .net_req_i(net_req_i), .net_we_i(net_we_i), .net_addr_i(net_addr_i),
    .net_wdata_i(net_wdata_i), .net_ack_o(net_ack_o), .net_rdata_o(net_rdata_o),
    .sbhe_seen_o(sbhe_seen_o));
  shm_chk shm_chk_i (.clk_i(clk_i), .rst_i(rst_i), .sbhe(shm_if_i.sbhe), .memr(shm_if_i.memr),
    .memw(shm_if_i.memw), .rom_window_match(shm_if_i.rom_window_match),
    .sram_window_match(shm_if_i.sram_window_match), .dsd_oe_n(shm_if_i.dsd_oe_n),
    .iochrdy_oe_n(shm_if_i.iochrdy_oe_n), .rom_chip_select_n_o(rom_chip_select_n_o),
    .sram_output_enable_n_o(sram_output_enable_n_o), .sram_write_strobe_n_o(sram_write_strobe_n_o),
    .private_data_bus_oe_n_o(private_data_bus_oe_n_o), .sbhe_seen_o(sbhe_seen_o));
  //////////////////////////////////////////////////
  // private memories; undriven bus shows a moving pattern
  function automatic logic [7:0] rom_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'ha5;
  endfunction
  always @(posedge clk_i) noise_q <= noise_q + 8'h35;
  assign private_data_bus_i = !rom_chip_select_n_o ? rom_byte(private_addr_o) :
    (!sram_output_enable_n_o ? mem[private_addr_o] : noise_q);
  always @(posedge sram_write_strobe_n_o) if (!rst_i) mem[private_addr_o] = private_data_bus_o;
  //////////////////////////////////////////////////
  function automatic logic [31:0] expect_rd(input cmd_t c);
    logic [7:0] lo, hi;
    logic [15:0] m;
    lo = c.rom ? rom_byte(c.addr & 16'hfffe) : ref_mem[c.addr & 16'hfffe];
    hi = c.rom ? rom_byte(c.addr | 16'h0001) : ref_mem[c.addr | 16'h0001];
    // 16-bit cycle: word on the bus, byte lanes picked by width and address
    if (wide_seen && (!c.rom || rom_wide_cycles_i)) begin
      m = c.wide ? 16'hffff : (c.addr[0] ? 16'hff00 : 16'h00ff);
      return {m, {hi, lo} & m};
    end
    return {24'h00ff00, c.rom ? rom_byte(c.addr) : ref_mem[c.addr]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic push(input cmd_t c);
    int n;
    n = 0;
    wide_seen = wide_seen | c.wide;
    if (c.we && c.wide) begin
      ref_mem[c.addr & 16'hfffe] = c.data[7:0];
      ref_mem[c.addr | 16'h0001] = c.data[15:8];
    end else if (c.we) begin
      ref_mem[c.addr] = (wide_seen && c.addr[0]) ? c.data[15:8] : c.data[7:0];
    end else begin
      exp_q.push_back(expect_rd(c));
    end
    cmd_valid_i <= 1'b1;
    cmd_i <= c;
    do begin
      @(negedge clk_i);
      n++;
      refused = refused | !cmd_ready_o;
    end while (cmd_ready_o !== 1'b1 && n < 5000);
    if (n >= 5000) fail_count++;
    @(posedge clk_i);
  endtask
  task automatic wait_idle(input string name);
    int n;
    int q;
    n = 0;
    q = 0;
    cmd_valid_i <= 1'b0;
    while ((exp_q.size() != 0 || q < 120) && n < 40000) begin
      @(posedge clk_i);
      n++;
      q = (shm_if_i.memr || shm_if_i.memw) ? 0 : q + 1;
    end
    if (n >= 40000) fail_count++;
    refresh_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    refresh_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    $display("test %s finished, %0d mismatches so far", name, fail_count);
  endtask
  task automatic net_op(input logic we, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    net_req_i <= 1'b1;
    net_we_i <= we;
    net_addr_i <= a;
    net_wdata_i <= d;
    do begin
      @(negedge clk_i);
      n++;
    end while (net_ack_o !== 1'b1 && n < 500);
    if (!we) chk({8'h00, net_rdata_o}, {8'h00, ref_mem[a]});
    if (we) ref_mem[a] = d;
    @(posedge clk_i);
    net_req_i <= 1'b0;
    repeat (60) @(posedge clk_i);
  endtask
  //////////////////////////////////////////////////
  always @(negedge clk_i) begin
    if (shm_if_i.iochrdy === 1'b0) stall++;
    if (rsp_valid_o === 1'b1) begin
      e = exp_q.size() != 0 ? exp_q.pop_front() : 32'hffff0000;
      chk(rsp_data_o & e[31:16], e[15:0] & e[31:16]);
    end
  end
  initial begin
    #(400000.0);
    fail_count++;
    $display("watchdog expired");
    print_verdict();
  end
  initial begin
    logic [31:0] r;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] + 8'h33;
      ref_mem[i] = i[7:0] + 8'h33;
    end
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 6; i++) push('{i == 5, i < 3, 1'b0, 16'h0040 + 16'(i % 3 * 2), 16'(i)});
    wait_idle("narrow");
    chk({15'h0000, sbhe_seen_o}, 16'h0000);
    push('{1'b0, 1'b0, 1'b1, 16'h0040, 16'h0000});
    for (int w = 0; w < 2; w++) begin
      wait_idle("rom");
      rom_wide_cycles_i <= w[0];
      @(posedge clk_i);
      push('{1'b1, 1'b0, 1'b1, 16'hfffe, 16'h0000});
      push('{1'b1, 1'b0, 1'b0, 16'hffff, 16'h0000});
    end
    wait_idle("rom");
    chk({15'h0000, sbhe_seen_o}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) push('{1'b0, 1'b1, 1'b1, 16'h8004, 16'hbeef});
      if (i == 3) net_op(1'b1, 16'h8006, 8'h77);
      stall = 0;
      push('{1'b0, 1'b0, 1'b1, 16'h8000 + 16'(i * 2), 16'h0000});
      wait_idle("prefetch");
      chk({15'h0000, stall != 0}, {15'h0000, i != 1});
    end
    stall = 0;
    refused = 1'b0;
    // hit read starts a prefetch that delays the first write-back
    push('{1'b0, 1'b0, 1'b1, 16'h8008, 16'h0000});
    for (int i = 0; i < 12; i++) begin
      push('{1'b0, 1'b1, 1'b1, 16'h9000 + 16'(i * 2), 16'($random(seed))});
    end
    wait_idle("posting");
    chk({15'h0000, refused}, 16'h0001);
    chk({15'h0000, stall != 0}, 16'h0001);
    for (int i = 0; i < 12; i++) push('{1'b0, 1'b0, 1'b1, 16'h9000 + 16'(i * 2), 16'h0000});
    wait_idle("readback");
    chk({15'h0000, cmd_ready_o}, 16'h0001);
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      push('{r[2:0] == 3'h0, r[2:0] != 3'h0 && r[3], r[4],
        16'h0100 + {9'h000, r[10:5], !r[4] && r[11]}, r[31:16]});
    end
    wait_idle("random");
    for (int i = 0; i < 6; i++) begin
      net_op(i[0], 16'h0100 + 16'(i), 8'($random(seed)));
      push('{1'b0, 1'b0, 1'b0, 16'h0100 + 16'(i), 16'h0000});
      wait_idle("network");
    end
    print_verdict();
  end
endmodule
